/* File: design/odsc_pkg.sv */
// constants and types shared by the octal converter serial command port
package odsc_pkg;

  // frame layout, sent most significant bit first
  localparam int FRAME_BITS = 16;
  localparam int DATA_BITS = 12;
  localparam int CODE_BITS = 4;
  localparam int CHANNELS = 8;
  localparam int CODE_MSB = 15;
  localparam int CODE_LSB = 12;
  localparam int DATA_MSB = 11;
  localparam int MASK_MSB = 7;
  localparam int REGULATOR_BIT = 8;

  // falling-edge counts inside a frame
  localparam logic [7:0] EDGE_FRAME = 8'h10;
  localparam logic [7:0] EDGE_ABORT = 8'h0F;
  localparam logic [7:0] EDGE_MARK = 8'h0E;
  localparam logic [7:0] EDGE_ECHO = 8'h0F;
  localparam logic [7:0] EDGE_SAT = 8'hFF;

  // shift register values at reset and at frame start, channel level at reset
  localparam logic [15:0] SHIFT_RESET = 16'h0000;
  localparam logic [15:0] SHIFT_PRELOAD = 16'h0001;
  localparam logic [11:0] LEVEL_RESET = 12'h000;

  // command codes of the top four bits
  localparam logic [3:0] CMD_STAGED = 4'h8;
  localparam logic [3:0] CMD_DIRECT = 4'h9;
  localparam logic [3:0] CMD_UPDATE_SEL = 4'hA;
  localparam logic [3:0] CMD_FIRST_CH = 4'hB;
  localparam logic [3:0] CMD_BROADCAST = 4'hC;
  localparam logic [3:0] CMD_PD_HIZ = 4'hD;
  localparam logic [3:0] CMD_PD_100K = 4'hE;
  localparam logic [3:0] CMD_PD_2K5 = 4'hF;

  // output termination codes
  localparam logic [1:0] TERM_ACTIVE = 2'h0;
  localparam logic [1:0] TERM_HIZ = 2'h1;
  localparam logic [1:0] TERM_100K = 2'h2;
  localparam logic [1:0] TERM_2K5 = 2'h3;

  // write mode values
  localparam logic MODE_STAGED = 1'b0;
  localparam logic MODE_DIRECT = 1'b1;

  // wake-up delay after power-down, least time so rounded up
  localparam int CLOCK_PERIOD_NS = 4;
  localparam int WAKE_TIME_NS = 8000;
  localparam logic [10:0] WAKE_CYCLES =
    11'((WAKE_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS);
  localparam logic [10:0] WAKE_IDLE = 11'h000;
  localparam logic [10:0] WAKE_LAST = 11'h001;

  // frame fifo shape
  localparam int FIFO_DEPTH = 16;

  // serial front end states
  typedef enum logic [1:0] {
    ODSC_IDLE = 2'b01,
    ODSC_SHIFT = 2'b10
  } odsc_state_e;

endpackage : odsc_pkg

/* File: design/odsc_top.sv */
// serial command port and channel register file of an octal string converter
//
// Contract
// R1: a frame is sixteen falling clock edges
// R2: sample serial input on falling edges, shift
// R3: host never lowers select on falling edge
// R4: rising frame select executes the command
// R5: host raises select between edges sixteen, seventeen
// R6: rise before fifteenth edge aborts the frame
// R7: beyond seventeenth edge, input echoes on output
// R8: host holds select high minimum time
// R9: host idles select high between frames
// R10: chains take n times sixteen edges
// R11: chain shares clock and select, output-to-input
// R12: output low fourteen edges, high on fifteenth
// R13: next sixteen edges echo first sixteen bits
// R14: output from shift stage, changes on falls
// R15: msb first, four code bits, twelve data
// R16: codes zero to seven load channel registers
// R17: code eight staged, nine direct write mode
// R18: codes ten to twelve ignore write mode
// R19: codes thirteen to fifteen power channels down
// R20: powered-down registers keep and accept writes
// R21: output returns to register after recovery delay
// R22: codes are straight binary, 0 to 4095
// R23: powers up staged, mode changes only by command
// R24: staged loads register, direct loads output too
// R25: update-select moves chosen outputs, sets regulator
// R26: first-channel command loads it, updates all
// R27: broadcast loads all registers and outputs
// R28: reset clears registers, shifter, serial output
`timescale 1ns/10ps

// frame word buffer between the serial front end and the decoder
module odsc_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH]; // word storage
  logic [AW-1:0] wr_ptr; // next slot to fill
  logic [AW-1:0] rd_ptr; // oldest word
  logic [AW:0] fill; // words held
  logic push;
  logic pop;

  assign in_ready = fill != FULL;
  assign out_valid = fill != '0;
  assign out_data = mem[rd_ptr];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // storage write, no reset needed for data
  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // pointers wrap naturally for a power-of-two depth
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end

  // fill level tracks push and pop together
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      fill <= '0;
    end else if (push & ~pop) begin
      fill <= fill + 1'b1;
    end else if (pop & ~push) begin
      fill <= fill - 1'b1;
    end
  end
endmodule : odsc_fifo

// serial front end, decoder and channel state
module odsc_top
  import odsc_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // serial pins, inputs asynchronous to clock
  input wire logic sclk,
  input wire logic sync_n,
  input wire logic din,
  output logic dout,
  // decoder stall from system logic
  input wire logic hold_apply,
  output logic frame_ready,
  // channel state
  output logic [7:0][11:0] ch_level,
  output logic [7:0][11:0] ch_out,
  output logic [7:0][1:0] ch_term,
  output logic direct_mode,
  output logic regulator_en
);

  // edge of a synchronised level
  function automatic logic edge_seen(input logic older, input logic newer,
                                     input logic rising);
    return rising ? (~older & newer) : (older & ~newer);
  endfunction : edge_seen

  logic [2:0] sclk_pipe; // clock pin synchroniser plus history
  logic [2:0] sync_pipe; // select pin synchroniser plus history
  logic [2:0] din_pipe; // data pin, aligned to clock history
  logic din_s; // data as it stood before the fall
  logic sclk_fall; // falling serial clock edge
  logic frame_open; // select went low
  logic frame_close; // select went high
  odsc_state_e state; // front end state
  logic [7:0] edge_cnt; // falling edges seen in frame
  logic [15:0] shift_word; // input shift register
  logic first_bit; // first bit of the frame
  logic frame_done; // complete frame at select rise
  logic fifo_in_ready; // buffer can take a word
  logic fifo_out_valid; // buffered word waiting
  logic [15:0] cmd_word; // word at the buffer head
  logic pop; // decoder takes the head word
  logic [3:0] cmd_code; // command or address field
  logic [11:0] cmd_data; // data field
  logic [7:0] load_mask; // registers loaded with data
  logic [7:0] upd_mask; // outputs refreshed
  logic [7:0] pd_mask; // channels powered down
  logic [1:0] pd_term; // termination requested
  logic [10:0] wake_cnt [CHANNELS]; // recovery countdown per channel
  logic [15:0] last_word; // last executed word

  // two flops before any use, third keeps history
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sclk_pipe <= 3'h7; // idle level of the link clock, no false edge
      sync_pipe <= 3'h7;
      din_pipe <= 3'h0;
    end else begin
      sclk_pipe <= {sclk_pipe[1:0], sclk};
      sync_pipe <= {sync_pipe[1:0], sync_n};
      din_pipe <= {din_pipe[1:0], din};
    end
  end

  assign din_s = din_pipe[2];
  assign sclk_fall = edge_seen(sclk_pipe[2], sclk_pipe[1], 1'b0); // [R2]
  assign frame_open = edge_seen(sync_pipe[2], sync_pipe[1], 1'b0);
  assign frame_close = edge_seen(sync_pipe[2], sync_pipe[1], 1'b1);

  // frame state, select low opens and select high closes
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state <= ODSC_IDLE;
    end else begin
      unique case (state)
        ODSC_IDLE: begin
          if (frame_open) begin
            state <= ODSC_SHIFT;
          end
        end
        ODSC_SHIFT: begin
          if (frame_close) begin
            state <= ODSC_IDLE;
          end
        end
      endcase
    end
  end

  // falling edge count, saturates for long chains
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      edge_cnt <= 8'h00;
    end else if (frame_open) begin
      edge_cnt <= 8'h00;
    end else if (state == ODSC_SHIFT && sclk_fall && !frame_close &&
                 edge_cnt != EDGE_SAT) begin
      edge_cnt <= edge_cnt + 8'h01; // [R1] [R10]
    end
  end

  // shift register; preload marks the output high on the fifteenth fall
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      shift_word <= SHIFT_RESET; // [R28]
    end else if (frame_open) begin
      shift_word <= SHIFT_PRELOAD; // [R12]
    end else if (state == ODSC_SHIFT && sclk_fall && !frame_close) begin
      shift_word <= {shift_word[14:0], din_s}; // [R2] [R15]
    end
  end

  // serial output from the stage fifteen deep, moved only on falls
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dout <= 1'b0; // [R28]
    end else if (state == ODSC_SHIFT && sclk_fall && !frame_close) begin
      dout <= shift_word[14]; // [R7] [R12] [R13] [R14]
    end
  end

  // first bit of each frame, kept for the echo check
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      first_bit <= 1'b0;
    end else if (state == ODSC_SHIFT && sclk_fall && edge_cnt == 8'h00) begin
      first_bit <= din_s;
    end
  end

  // short frames are dropped; the last sixteen bits form the command
  assign frame_done = state == ODSC_SHIFT && frame_close &&
                      edge_cnt >= EDGE_FRAME; // [R4] [R6] [R10]

  // frame buffer; a full buffer drops the frame and shows not ready
  odsc_fifo #(.WIDTH(FRAME_BITS), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clock(clock),
    .rst(rst),
    .in_valid(frame_done),
    .in_ready(fifo_in_ready),
    .in_data(shift_word),
    .out_valid(fifo_out_valid),
    .out_ready(!hold_apply),
    .out_data(cmd_word)
  );

  // buffer readiness as a registered status
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      frame_ready <= 1'b0;
    end else begin
      frame_ready <= fifo_in_ready;
    end
  end

  assign pop = fifo_out_valid & !hold_apply;
  assign cmd_code = cmd_word[CODE_MSB:CODE_LSB]; // [R15]
  assign cmd_data = cmd_word[DATA_MSB:0];

  // command decode into load, refresh and power-down masks
  always_comb begin
    load_mask = 8'h00;
    upd_mask = 8'h00;
    pd_mask = 8'h00;
    pd_term = TERM_ACTIVE;
    if (pop) begin
      if (!cmd_code[3]) begin
        // channel write, refresh only in direct mode
        load_mask[cmd_code[2:0]] = 1'b1; // [R16] [R20]
        if (direct_mode) begin
          upd_mask[cmd_code[2:0]] = 1'b1; // [R24]
        end
      end else begin
        unique case (cmd_code)
          CMD_UPDATE_SEL: upd_mask = cmd_data[MASK_MSB:0]; // [R18] [R25]
          CMD_FIRST_CH: begin
            load_mask = 8'h01; // [R26]
            upd_mask = 8'hFF;
          end
          CMD_BROADCAST: begin
            load_mask = 8'hFF; // [R27]
            upd_mask = 8'hFF;
          end
          CMD_PD_HIZ: begin
            pd_mask = cmd_data[MASK_MSB:0]; // [R19]
            pd_term = TERM_HIZ;
          end
          CMD_PD_100K: begin
            pd_mask = cmd_data[MASK_MSB:0];
            pd_term = TERM_100K;
          end
          CMD_PD_2K5: begin
            pd_mask = cmd_data[MASK_MSB:0];
            pd_term = TERM_2K5;
          end
          default: begin
            // mode codes handled by the mode flop
          end
        endcase
      end
    end
  end

  // channel registers, straight binary codes
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ch_level <= '0; // [R28]
    end else begin
      for (int i = 0; i < CHANNELS; i++) begin
        if (load_mask[i]) begin
          ch_level[i] <= cmd_data; // [R22]
        end
      end
    end
  end

  // channel outputs take new data or the held register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ch_out <= '0;
    end else begin
      for (int i = 0; i < CHANNELS; i++) begin
        if (upd_mask[i]) begin
          ch_out[i] <= load_mask[i] ? cmd_data : ch_level[i]; // [R24]
        end
      end
    end
  end

  // write mode, staged after reset
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      direct_mode <= MODE_STAGED; // [R23]
    end else if (pop && cmd_code == CMD_STAGED) begin
      direct_mode <= MODE_STAGED; // [R17]
    end else if (pop && cmd_code == CMD_DIRECT) begin
      direct_mode <= MODE_DIRECT; // [R17]
    end
  end

  // input level regulator enable from update-select
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      regulator_en <= 1'b0;
    end else if (pop && cmd_code == CMD_UPDATE_SEL) begin
      regulator_en <= cmd_data[REGULATOR_BIT]; // [R25]
    end
  end

  // termination and recovery; a refresh of a sleeping channel wakes it
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ch_term <= '0;
      for (int i = 0; i < CHANNELS; i++) begin
        wake_cnt[i] <= WAKE_IDLE;
      end
    end else begin
      for (int i = 0; i < CHANNELS; i++) begin
        if (pd_mask[i]) begin
          ch_term[i] <= pd_term; // [R19]
          wake_cnt[i] <= WAKE_IDLE;
        end else if (upd_mask[i] && ch_term[i] != TERM_ACTIVE &&
                     wake_cnt[i] == WAKE_IDLE) begin
          wake_cnt[i] <= WAKE_CYCLES; // [R21]
        end else if (wake_cnt[i] != WAKE_IDLE) begin
          wake_cnt[i] <= wake_cnt[i] - WAKE_LAST;
          if (wake_cnt[i] == WAKE_LAST) begin
            ch_term[i] <= TERM_ACTIVE; // [R21]
          end
        end
      end
    end
  end

  // last executed word, watched by the checks
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      last_word <= SHIFT_RESET;
    end else if (pop) begin
      last_word <= cmd_word;
    end
  end

  // checks on the front end
  property p_shift_in;
    @(posedge clock) disable iff (rst)
    state == ODSC_SHIFT && sclk_fall && !frame_close
    |=> shift_word[0] == $past(din_s) &&
        shift_word[15:1] == $past(shift_word[14:0]);
  endproperty
  a_shift_in: assert property (p_shift_in) // [R2]
    else $error("shift register did not take the serial bit");

  // frame pushed into an empty buffer, then taken by the decoder
  sequence s_frame_end;
    frame_done && !fifo_out_valid;
  endsequence
  sequence s_applied;
    pop;
  endsequence
  property p_execute;
    @(posedge clock) disable iff (rst)
    s_frame_end ##1 s_applied |=> last_word == $past(shift_word, 2);
  endproperty
  a_execute: assert property (p_execute) // [R4]
    else $error("completed frame was not executed");

  property p_abort;
    @(posedge clock) disable iff (rst)
    state == ODSC_SHIFT && frame_close && edge_cnt < EDGE_ABORT
    |=> state == ODSC_IDLE &&
        u_fifo.fill == $past(u_fifo.fill) - $past(pop) &&
        ($stable(last_word) || $past(pop));
  endproperty
  a_abort: assert property (p_abort) // [R6]
    else $error("short frame was not discarded");

  property p_mark_low;
    @(posedge clock) disable iff (rst)
    state == ODSC_SHIFT && sclk_fall && !frame_close && edge_cnt < EDGE_MARK
    |=> !dout;
  endproperty
  a_mark_low: assert property (p_mark_low) // [R12]
    else $error("serial output high too early");

  property p_mark_high;
    @(posedge clock) disable iff (rst)
    state == ODSC_SHIFT && sclk_fall && !frame_close && edge_cnt == EDGE_MARK
    |=> dout;
  endproperty
  a_mark_high: assert property (p_mark_high) // [R12]
    else $error("serial output not high on fifteenth edge");

  property p_echo;
    @(posedge clock) disable iff (rst)
    state == ODSC_SHIFT && sclk_fall && !frame_close && edge_cnt == EDGE_ECHO
    |=> dout == first_bit;
  endproperty
  a_echo: assert property (p_echo) // [R13]
    else $error("serial output did not echo the first bit");

  property p_dout_on_fall;
    @(posedge clock) disable iff (rst)
    !$stable(dout) |-> $past(sclk_fall);
  endproperty
  a_dout_on_fall: assert property (p_dout_on_fall) // [R14]
    else $error("serial output moved without a falling edge");

  // checks on the decoder
  property p_staged;
    @(posedge clock) disable iff (rst)
    pop && !cmd_code[3] && direct_mode == MODE_STAGED
    |=> $stable(ch_out) && ch_level[$past(cmd_code[2:0])] == $past(cmd_data);
  endproperty
  a_staged: assert property (p_staged) // [R24]
    else $error("staged write disturbed the outputs");

  property p_direct;
    @(posedge clock) disable iff (rst)
    pop && !cmd_code[3] && direct_mode == MODE_DIRECT
    |=> ch_out[$past(cmd_code[2:0])] == $past(cmd_data);
  endproperty
  a_direct: assert property (p_direct) // [R24]
    else $error("direct write did not reach the output");

  property p_first_ch;
    @(posedge clock) disable iff (rst)
    pop && cmd_code == CMD_FIRST_CH
    |=> ch_out[0] == $past(cmd_data) && ch_out[7] == $past(ch_level[7]) &&
        direct_mode == $past(direct_mode);
  endproperty
  a_first_ch: assert property (p_first_ch) // [R26]
    else $error("first-channel command wrong");

  property p_broadcast;
    @(posedge clock) disable iff (rst)
    pop && cmd_code == CMD_BROADCAST
    |=> ch_level == {CHANNELS{$past(cmd_data)}} &&
        ch_out == {CHANNELS{$past(cmd_data)}} &&
        direct_mode == $past(direct_mode);
  endproperty
  a_broadcast: assert property (p_broadcast) // [R27]
    else $error("broadcast did not load every channel");

  property p_mode;
    @(posedge clock) disable iff (rst)
    pop && cmd_code == CMD_DIRECT |=> direct_mode == MODE_DIRECT;
  endproperty
  a_mode: assert property (p_mode) // [R17]
    else $error("direct mode command ignored");

  property p_wake;
    @(posedge clock) disable iff (rst)
    wake_cnt[0] == WAKE_LAST && !pd_mask[0] |=> ch_term[0] == TERM_ACTIVE;
  endproperty
  a_wake: assert property (p_wake) // [R21]
    else $error("channel did not recover after delay");

  property p_reset;
    @(posedge clock)
    $past(rst) && rst |-> ch_level == '0 && !dout &&
      shift_word == SHIFT_RESET && direct_mode == MODE_STAGED;
  endproperty
  a_reset: assert property (p_reset) // [R28] [R23]
    else $error("reset values wrong");

endmodule : odsc_top

/* File: testbench/odsc_host.sv */
// host serial controller model driving select, clock and data pins
`timescale 1ns/10ps
module odsc_host #(
  parameter int HALF = 24
) (
  // serial pins toward the device
  output logic sclk,
  output logic sync_n,
  output logic din,
  // serial output of the device
  input wire logic dout
);
  logic [47:0] cap; // serial output seen after each fall

  // idle pins: clock stands high, select idles high
  initial begin
    sclk = 1'b1;
    sync_n = 1'b1;
    din = 1'b0;
    cap = '0;
  end

  // one frame of n falls, msb first, then a select high gap
  task automatic send(input logic [47:0] word, input int n);
    cap = '0;
    sync_n = 1'b0; // lowered in the high phase, away from falls
    #HALF;
    for (int k = n - 1; k >= 0; k--) begin // msb first
      din = word[k];
      #(HALF / 2);
      sclk = 1'b0;
      #HALF;
      sclk = 1'b1;
      #(HALF / 2);
      cap = {cap[46:0], dout}; // next device in the chain reads dout
    end
    sync_n = 1'b1; // after the last fall, before any further one
    din = ~din; // released line shows no stale bit
    #(2 * HALF); // select high gap between frames
  endtask : send
endmodule : odsc_host

/* File: testbench/odsc_top_tb.sv */
// self-checking bench of the octal converter serial command port
`timescale 1ns/10ps
module odsc_top_tb
  import odsc_pkg::*;
;
  localparam int EXEC_WAIT = 10; // close detect plus two cycles, margin
  localparam int NROWS = 19;
  // one ordinary case: frame word and the state it should leave
  typedef struct packed {
    logic [15:0] word;
    logic [2:0] ch;
    logic [11:0] lvl;
    logic [11:0] out;
    logic [1:0] term;
    logic mode;
    logic reg_en;
  } odsc_row_s;
  logic clock;
  logic rst;
  logic hold_apply;
  wire sclk;
  wire sync_n;
  wire din;
  logic dout;
  logic frame_ready;
  logic [7:0][11:0] ch_level;
  logic [7:0][11:0] ch_out;
  logic [7:0][1:0] ch_term;
  logic direct_mode;
  logic regulator_en;
  logic [7:0][11:0] exp_lvl; // expected channel registers
  int error_cnt = 0;
  int checks_done = 0;
  int sent;
  odsc_row_s rows [NROWS] = '{
    '{16'h0123, 3'd0, 12'h123, 12'h000, 2'h0, 1'b0, 1'b0},
    '{16'h7ABC, 3'd7, 12'hABC, 12'h000, 2'h0, 1'b0, 1'b0},
    '{16'h9000, 3'd7, 12'hABC, 12'h000, 2'h0, 1'b1, 1'b0},
    '{16'h3FFF, 3'd3, 12'hFFF, 12'hFFF, 2'h0, 1'b1, 1'b0},
    '{16'h8000, 3'd3, 12'hFFF, 12'hFFF, 2'h0, 1'b0, 1'b0},
    '{16'h2555, 3'd2, 12'h555, 12'h000, 2'h0, 1'b0, 1'b0},
    '{16'hA004, 3'd2, 12'h555, 12'h555, 2'h0, 1'b0, 1'b0},
    '{16'hA100, 3'd7, 12'hABC, 12'h000, 2'h0, 1'b0, 1'b1},
    '{16'hB321, 3'd0, 12'h321, 12'h321, 2'h0, 1'b0, 1'b1},
    '{16'hB456, 3'd7, 12'hABC, 12'hABC, 2'h0, 1'b0, 1'b1},
    '{16'hC800, 3'd5, 12'h800, 12'h800, 2'h0, 1'b0, 1'b1},
    '{16'h9000, 3'd5, 12'h800, 12'h800, 2'h0, 1'b1, 1'b1},
    '{16'hB111, 3'd0, 12'h111, 12'h111, 2'h0, 1'b1, 1'b1},
    '{16'hC222, 3'd1, 12'h222, 12'h222, 2'h0, 1'b1, 1'b1},
    '{16'h8000, 3'd1, 12'h222, 12'h222, 2'h0, 1'b0, 1'b1},
    '{16'hD001, 3'd0, 12'h222, 12'h222, 2'h1, 1'b0, 1'b1},
    '{16'hE002, 3'd1, 12'h222, 12'h222, 2'h2, 1'b0, 1'b1},
    '{16'hF004, 3'd2, 12'h222, 12'h222, 2'h3, 1'b0, 1'b1},
    '{16'h0AAA, 3'd0, 12'hAAA, 12'h222, 2'h1, 1'b0, 1'b1}
  };

  // device under test
  odsc_top dut (
    .clock(clock),
    .rst(rst),
    .sclk(sclk),
    .sync_n(sync_n),
    .din(din),
    .dout(dout),
    .hold_apply(hold_apply),
    .frame_ready(frame_ready),
    .ch_level(ch_level),
    .ch_out(ch_out),
    .ch_term(ch_term),
    .direct_mode(direct_mode),
    .regulator_en(regulator_en)
  );

  // host controller on the serial pins, 48 ns link clock
  odsc_host #(.HALF(24)) host (
    .sclk(sclk),
    .sync_n(sync_n),
    .din(din),
    .dout(dout)
  );

  // 250 MHz system clock
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // compare seen against expected, count both
  task automatic check(input string what, input logic [95:0] seen,
                       input logic [95:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // n rising edges, then a small delay off the edge
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : wait_clk

  // counts and verdict, then stop
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_sim

  // main sequence
  initial begin
    rst = 1'b1;
    hold_apply = 1'b0;
    wait_clk(6);
    rst = 1'b0;
    // values straight after reset
    check("rst_level", ch_level, '0);
    check("rst_out", ch_out, '0);
    check("rst_dout", dout, 1'b0);
    check("rst_mode", direct_mode, MODE_STAGED);
    check("rst_term", ch_term, '0);
    $display("test reset done");
    wait_clk(5);
    // ordinary command table
    for (int i = 0; i < NROWS; i++) begin
      host.send({32'h0, rows[i].word}, FRAME_BITS);
      wait_clk(EXEC_WAIT);
      check("level", ch_level[rows[i].ch], rows[i].lvl);
      check("out", ch_out[rows[i].ch], rows[i].out);
      check("term", ch_term[rows[i].ch], rows[i].term);
      check("mode", direct_mode, rows[i].mode);
      check("regulator", regulator_en, rows[i].reg_en);
    end
    $display("test table done");
    // refresh of a powered-down channel, then the recovery delay
    host.send(48'hA001, FRAME_BITS);
    wait_clk(EXEC_WAIT);
    check("wake_out", ch_out[0], 12'hAAA);
    check("wake_term", ch_term[0], TERM_HIZ);
    wait_clk(int'(WAKE_CYCLES) - 40);
    check("wake_wait", ch_term[0], TERM_HIZ);
    wait_clk(60);
    check("wake_end", ch_term[0], TERM_ACTIVE);
    $display("test wake done");
    // frames closed after 14 and 15 falls leave everything alone
    for (int n = 14; n <= 15; n++) begin
      host.send(48'hFFFF, n);
      wait_clk(EXEC_WAIT);
      check("abort_lvl", ch_level, {{7{12'h222}}, 12'hAAA});
      check("abort_term", ch_term, 16'h0038);
    end
    $display("test abort done");
    // two words in one frame, device keeps the second
    host.send({16'h0, 16'h5A5A, 16'h6789}, 32);
    wait_clk(EXEC_WAIT);
    check("chain_dout", host.cap[31:0],
          {14'h0, 1'b1, 16'h5A5A, 1'b0});
    check("chain_kept", ch_level[6], 12'h789);
    check("chain_first", ch_level[5], 12'h222);
    $display("test chain done");
    // decoder stalled: fill the buffer until it refuses
    hold_apply = 1'b1;
    sent = 0;
    for (int i = 0; i < 20 && frame_ready === 1'b1; i++) begin
      host.send({32'h0, 1'b0, 3'(i), 12'h300 + 12'(i)}, FRAME_BITS);
      sent++;
    end
    check("fifo_fill", sent, FIFO_DEPTH);
    host.send(48'h0FFF, FRAME_BITS);
    wait_clk(1);
    hold_apply = 1'b0;
    wait_clk(100);
    for (int k = 0; k < 8; k++) begin
      exp_lvl[k] = 12'h308 + 12'(k);
    end
    check("fifo_drain", ch_level, exp_lvl);
    check("fifo_ready", frame_ready, 1'b1);
    $display("test fifo done");
    // reset in mid-run clears the state left by earlier tests
    rst = 1'b1;
    wait_clk(2);
    check("rst2_level", ch_level, '0);
    check("rst2_out", ch_out, '0);
    check("rst2_term", ch_term, '0);
    check("rst2_reg", regulator_en, 1'b0);
    rst = 1'b0;
    wait_clk(5);
    $display("test reset again done");
    end_sim();
  end
endmodule : odsc_top_tb
